// [verilog/flash_read_cfg.svh]
`ifndef FLASH_READ_CFG_SVH
`define FLASH_READ_CFG_SVH

// address and data geometry
`define ADDR_W          20
`define PART_HI         19
`define PART_LO         18
`define PART_CNT        4
`define OFFS_HI         7
`define OFFS_LO         0

// read commands, the configuration pair and the write setups
`define CMD_READ_ARRAY  8'hff
`define CMD_READ_ID     8'h90
`define CMD_READ_QUERY  8'h98
`define CMD_READ_STATUS 8'h70
`define CMD_CFG_SETUP   8'h60
`define CMD_CFG_CONFIRM 8'h03
`define CMD_ERASE       8'h20
`define CMD_PROGRAM     8'h40
`define CMD_PROGRAM_ALT 8'h10
`define CMD_FAST_PROG   8'h30
`define CMD_PROT_PROG   8'hc0

// identifier space offsets
`define ID_MAKER        8'h00
`define ID_PART         8'h01
`define ID_LOCK         8'h02
`define ID_CONFIG       8'h05
`define ID_PROT_LOCK    8'h80
`define ID_PROT_LAST    8'h88
`define PROT_WORDS      9
`define PROT_IDX_W      4

// read configuration fields
`define CFG_RESET       16'h8000
`define CFG_ASYNC_BIT   15
`define CFG_LAT_HI      13
`define CFG_LAT_LO      11
`define CFG_LEN_HI      2
`define CFG_LEN_LO      0
`define LEN_CODE_4      3'h1
`define LEN_CODE_8      3'h2
`define LEN_CODE_16     3'h3
`define LEN_4           5'h04
`define LEN_8           5'h08
`define LEN_16          5'h10

// data values
`define INVALID_WORD    16'hffff
`define STATUS_PAD      8'h00
`define LOCK_PAD        14'h0000

// synchronised pin vector layout
`define PIN_W           41
`define PIN_CE          0
`define PIN_OE          1
`define PIN_WE          2
`define PIN_ALS         3
`define PIN_BCLK        4
`define PIN_ADDR_LO     5
`define PIN_ADDR_HI     24
`define PIN_DQ_LO       25
`define PIN_DQ_HI       40

`endif

// [verilog/flash_read_pkg.sv]
`include "flash_read_cfg.svh"

package flash_read_pkg;

  // per-partition read state, gray along array-ident-query-status
  typedef enum logic [1:0] {
    PS_ARRAY  = 2'h0,
    PS_IDENT  = 2'h1,
    PS_QUERY  = 2'h3,
    PS_STATUS = 2'h2
  } part_state_t;

  // burst sequencer, gray along the usual path
  typedef enum logic [1:0] {
    BS_IDLE    = 2'h0,
    BS_LATCH   = 2'h1,
    BS_LATENCY = 2'h3,
    BS_STREAM  = 2'h2
  } burst_state_t;

  // whole state of the read controller
  typedef struct packed {
    logic [15:0]              cfg;
    part_state_t [3:0]        pstate;
    logic                     cfg_pend;
    burst_state_t             bst;
    logic [2:0]               lat_cnt;
    logic [4:0]               word_cnt;
    logic [`ADDR_W-1:0]       waddr;
    logic [15:0]              dq;
    logic                     dq_oe;
    logic                     wait_flag;
  } read_state_t;

endpackage

// [verilog/pin_sampler.sv]
// two-flop synchroniser with edge pulses, one lane per bit
module pin_sampler #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pins,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);

  // first stage, second stage, previous second stage
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } sync_t;

  sync_t s_q;  // registered state
  sync_t s_d;  // next state

  // shift chain; s1 feeds only s2
  always_comb begin
    s_d.s1 = pins;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
  end

  // plain registers, no reset needed on a pure delay line
  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  // edges compare stage two against its own history
  for (genvar i = 0; i < W; i++) begin : g_lane
    assign level[i] = s_q.s2[i];
    assign rise[i]  = s_q.s2[i] & ~s_q.s3[i];
    assign fall[i]  = ~s_q.s2[i] & s_q.s3[i];
  end

  // rst unused: the chain flushes itself within three cycles
  logic unused_rst;
  assign unused_rst = rst;

endmodule // pin_sampler

// [verilog/prot_store.sv]
`include "flash_read_cfg.svh"

// protection lock word and protection register words
module prot_store (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   wr_en,
  input  wire logic [`PROT_IDX_W-1:0] wr_idx,
  input  wire logic [15:0]            wr_data,
  input  wire logic [`PROT_IDX_W-1:0] rd_idx,
  output logic      [15:0]            rd_data
);

  // entry 0 is the lock word, 1..8 the register words
  typedef struct packed {
    logic [`PROT_WORDS-1:0][15:0] mem;
    logic [15:0]                  rdata;
  } store_t;

  store_t s_q;  // registered state
  store_t s_d;  // next state

  // write port and registered read
  always_comb begin
    s_d = s_q;
    if (wr_en && (wr_idx < `PROT_IDX_W'(`PROT_WORDS))) begin
      s_d.mem[wr_idx] = wr_data;
    end
    // out of range index reads as zero
    s_d.rdata = (rd_idx < `PROT_IDX_W'(`PROT_WORDS)) ? s_q.mem[rd_idx] : 16'h0000;
    // contents survive reset, only the output clears
    if (rst) begin
      s_d.rdata = 16'h0000;
    end
  end

  always_ff @(posedge clk) begin
    s_q <= s_d;
  end

  assign rd_data = s_q.rdata;

endmodule // prot_store

// [verilog/flash_sync_read_mode_control.sv]
// Operation
// - burst only after configuration register selects it
// - burst of four, eight, sixteen or continuous
// - bursts serve array and non-array reads
// - address captured when latch strobe deasserts
// - strobe held low: capture at clock edge
// - first word after configured latency count
// - later words on successive valid clock edges
// - non-array burst repeats the same word
// - wait flags invalid data on clock edges
// - command FFh sets partition to array read
// - reset puts all partitions in async array
// - busy partition gives invalid array data until done
// - array command after suspend gives array read
// - command 90h selects identifier space for partition
// - identifier read allowed while partition busy
// - offsets 00,01,05 give maker, part, config
// - offset 02h gives lock and lock-down flags
// - offsets 80h..88h give protection lock and data
// - query state returns database word by offset
// - query read allowed while partition busy
// - each partition keeps its own read state
// - status on low byte, upper byte zero
`include "flash_read_cfg.svh"

module flash_sync_read_mode_control #(
  parameter logic [15:0] MAKER_CODE = 16'h00a5,  // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h5a01   // arbitrary value
) (
  input  wire logic                      REF_CLK,
  input  wire logic                      RST,
  input  wire logic                      BUS_CLK,
  input  wire logic                      CE_N,
  input  wire logic                      OE_N,
  input  wire logic                      WE_N,
  input  wire logic                      ADDRESS_LATCH_STROBE_N,
  input  wire logic [`ADDR_W-1:0]        ADDR,
  input  wire logic [15:0]               DQ_I,
  output logic      [15:0]               DQ_O,
  output logic                           DQ_OE,
  output logic                           WAIT_O,
  output logic      [`ADDR_W-1:0]        ARRAY_ADDR,
  input  wire logic [15:0]               ARRAY_DATA,
  input  wire logic [15:0]               QUERY_DATA,
  input  wire logic [7:0]                STATUS_DATA,
  input  wire logic [1:0]                BLOCK_LOCK,
  input  wire logic [`PART_CNT-1:0]      PART_BUSY,
  input  wire logic                      PROT_WR_EN,
  input  wire logic [`PROT_IDX_W-1:0]    PROT_WR_IDX,
  input  wire logic [15:0]               PROT_WR_DATA
);
  import flash_read_pkg::*;

  flash_read_pkg::read_state_t s_q;  // registered state
  flash_read_pkg::read_state_t s_d;  // next state
  // synchronised pins and their edges
  logic [`PIN_W-1:0] pin_lvl;
  logic [`PIN_W-1:0] pin_rise;
  logic [`PIN_W-1:0] pin_fall;

  // every pin, the bus clock included, passes two flops
  pin_sampler #(
    .W (`PIN_W)
  ) u_sampler (
    .clk   (REF_CLK),
    .rst   (RST),
    .pins  ({DQ_I, ADDR, BUS_CLK, ADDRESS_LATCH_STROBE_N, WE_N, OE_N, CE_N}),
    .level (pin_lvl),
    .rise  (pin_rise),
    .fall  (pin_fall)
  );

  // convenient views of the sampled pins
  logic                 ce_n_s;    // chip enable, low active
  logic                 oe_n_s;    // output enable, low active
  logic                 we_rise;   // end of a command write
  logic                 als_n_s;   // latch strobe level
  logic                 als_rise;  // latch strobe deasserted
  logic                 bclk_rise; // valid bus clock edge
  logic [`ADDR_W-1:0]   addr_s;    // sampled address
  logic [15:0]          dq_s;      // sampled write data
  assign ce_n_s    = pin_lvl[`PIN_CE];
  assign oe_n_s    = pin_lvl[`PIN_OE];
  assign we_rise   = pin_rise[`PIN_WE];
  assign als_n_s   = pin_lvl[`PIN_ALS];
  assign als_rise  = pin_rise[`PIN_ALS];
  assign bclk_rise = pin_rise[`PIN_BCLK];
  assign addr_s    = pin_lvl[`PIN_ADDR_HI:`PIN_ADDR_LO];
  assign dq_s      = pin_lvl[`PIN_DQ_HI:`PIN_DQ_LO];

  // partition and state of the word being read
  logic [1:0]   rd_part;   // partition of current word
  part_state_t  rd_state;  // its read state
  logic         rd_busy;   // engine busy in that partition
  logic [7:0]   rd_offs;   // offset within base
  logic [15:0]  prot_word; // protection store output
  logic [`PROT_IDX_W-1:0] prot_idx;
  assign rd_part  = s_q.waddr[`PART_HI:`PART_LO];
  assign rd_state = s_q.pstate[rd_part];
  assign rd_busy  = PART_BUSY[rd_part];
  assign rd_offs  = s_q.waddr[`OFFS_HI:`OFFS_LO];
  assign prot_idx = `PROT_IDX_W'(rd_offs - `ID_PROT_LOCK);

  // protection lock word and register, read one cycle after address
  prot_store u_prot (
    .clk     (REF_CLK),
    .rst     (RST),
    .wr_en   (PROT_WR_EN),
    .wr_idx  (PROT_WR_IDX),
    .wr_data (PROT_WR_DATA),
    .rd_idx  (prot_idx),
    .rd_data (prot_word)
  );

  // word source chosen by the addressed partition's state
  logic [15:0] rd_word;   // word to present
  logic        rd_valid;  // false while array is busy

  always_comb begin
    rd_word  = `INVALID_WORD;
    rd_valid = 1'b1;
    unique case (rd_state)
      PS_ARRAY: begin
        rd_word  = rd_busy ? `INVALID_WORD : ARRAY_DATA;
        rd_valid = ~rd_busy;
      end
      PS_IDENT: begin
        if (rd_offs == `ID_MAKER) begin
          rd_word = MAKER_CODE;
        end else if (rd_offs == `ID_PART) begin
          rd_word = PART_CODE;
        end else if (rd_offs == `ID_CONFIG) begin
          rd_word = s_q.cfg;
        end else if (rd_offs == `ID_LOCK) begin
          // lock flags, bits 0 and 1
          rd_word = {`LOCK_PAD, BLOCK_LOCK};
        end else if (rd_offs >= `ID_PROT_LOCK && rd_offs <= `ID_PROT_LAST) begin
          rd_word = prot_word;
        end else begin
          // unlisted identifier offsets read zero
          rd_word = 16'h0000;
        end
      end
      PS_QUERY: begin
        rd_word = QUERY_DATA;
      end
      PS_STATUS: begin
        rd_word = {`STATUS_PAD, STATUS_DATA};
      end
    endcase
  end

  // burst length decode; other codes mean continuous
  logic       len_cont;  // continuous burst
  logic [4:0] len_words; // words per burst otherwise
  logic [2:0] len_code;
  assign len_code = s_q.cfg[`CFG_LEN_HI:`CFG_LEN_LO];
  always_comb begin
    len_cont  = 1'b0;
    len_words = `LEN_4;
    if (len_code == `LEN_CODE_4) begin
      len_words = `LEN_4;
    end else if (len_code == `LEN_CODE_8) begin
      len_words = `LEN_8;
    end else if (len_code == `LEN_CODE_16) begin
      len_words = `LEN_16;
    end else begin
      len_cont  = 1'b1;
    end
  end

  // burst can continue while length not met
  logic more_words;
  assign more_words = len_cont | (s_q.word_cnt < len_words);

  // command decoder and read sequencer
  always_comb begin
    s_d = s_q;
    // command writes, taken at end of write with chip selected
    if (we_rise && !ce_n_s) begin
      if (s_q.cfg_pend) begin
        s_d.cfg_pend = 1'b0;
        if (dq_s[7:0] == `CMD_CFG_CONFIRM) begin
          s_d.cfg = addr_s[15:0];
        end
      end else begin
        unique case (dq_s[7:0])
          `CMD_READ_ARRAY: begin
            s_d.pstate[addr_s[`PART_HI:`PART_LO]] = PS_ARRAY;
          end
          `CMD_READ_ID: begin
            s_d.pstate[addr_s[`PART_HI:`PART_LO]] = PS_IDENT;
          end
          `CMD_READ_QUERY: begin
            s_d.pstate[addr_s[`PART_HI:`PART_LO]] = PS_QUERY;
          end
          `CMD_READ_STATUS: begin
            s_d.pstate[addr_s[`PART_HI:`PART_LO]] = PS_STATUS;
          end
          // setup may be configuration or lock; both show status
          `CMD_CFG_SETUP: begin
            s_d.cfg_pend = 1'b1;
            s_d.pstate[addr_s[`PART_HI:`PART_LO]] = PS_STATUS;
          end
          // write setups switch only the addressed partition
          `CMD_ERASE, `CMD_PROGRAM, `CMD_PROGRAM_ALT, `CMD_FAST_PROG, `CMD_PROT_PROG: begin
            s_d.pstate[addr_s[`PART_HI:`PART_LO]] = PS_STATUS;
          end
          // suspend, resume, clear leave read states alone
          default: begin
            s_d.cfg_pend = s_q.cfg_pend;
          end
        endcase
      end
    end
    if (ce_n_s || oe_n_s) begin
      s_d.dq_oe     = 1'b0;
      s_d.bst       = BS_IDLE;
      s_d.wait_flag = 1'b1;
    end else if (s_q.cfg[`CFG_ASYNC_BIT]) begin
      // asynchronous reads follow the address, wait stays asserted
      s_d.dq_oe     = 1'b1;
      s_d.waddr     = addr_s;
      s_d.dq        = rd_word;
      s_d.wait_flag = 1'b1;
      s_d.bst       = BS_IDLE;
    end else begin
      // same sequencer for every read state
      s_d.dq_oe = 1'b1;
      unique case (s_q.bst)
        BS_IDLE: begin
          s_d.wait_flag = 1'b1;
          if (!als_n_s) begin
            s_d.bst = BS_LATCH;
          end
        end
        BS_LATCH: begin
          s_d.wait_flag = 1'b1;
          if (als_rise || (bclk_rise && !als_n_s)) begin
            s_d.waddr   = addr_s;
            s_d.lat_cnt = s_q.cfg[`CFG_LAT_HI:`CFG_LAT_LO];
            s_d.bst     = BS_LATENCY;
          end
        end
        BS_LATENCY: begin
          s_d.wait_flag = 1'b1;
          if (bclk_rise) begin
            if (s_q.lat_cnt == 3'h0) begin
              s_d.dq        = rd_word;
              // wait low only for valid data
              s_d.wait_flag = ~rd_valid;
              s_d.word_cnt  = 5'h01;
              s_d.bst       = BS_STREAM;
              if (rd_state == PS_ARRAY && rd_valid) begin
                s_d.waddr = s_q.waddr + `ADDR_W'(1);
              end
            end else begin
              s_d.lat_cnt = s_q.lat_cnt - 3'h1;
            end
          end
        end
        BS_STREAM: begin
          if (als_rise || (bclk_rise && !als_n_s && s_q.wait_flag && !more_words)) begin
            // a new address starts a fresh burst
            s_d.waddr     = addr_s;
            s_d.lat_cnt   = s_q.cfg[`CFG_LAT_HI:`CFG_LAT_LO];
            s_d.wait_flag = 1'b1;
            s_d.bst       = BS_LATENCY;
          end else if (bclk_rise) begin
            if (more_words) begin
              s_d.dq        = rd_word;
              s_d.wait_flag = ~rd_valid;
              // continuous bursts leave the word count unchanged
              if (!len_cont) begin
                s_d.word_cnt = s_q.word_cnt + 5'h01;
              end
              if (rd_state == PS_ARRAY && rd_valid) begin
                s_d.waddr = s_q.waddr + `ADDR_W'(1);
              end
            end else begin
              // burst length met: data no longer valid
              s_d.wait_flag = 1'b1;
            end
          end
        end
      endcase
    end
    if (RST) begin
      s_d.cfg       = `CFG_RESET;
      s_d.pstate    = {`PART_CNT{PS_ARRAY}};
      s_d.cfg_pend  = 1'b0;
      s_d.bst       = BS_IDLE;
      s_d.lat_cnt   = 3'h0;
      s_d.word_cnt  = 5'h00;
      s_d.waddr     = '0;
      s_d.dq        = 16'h0000;
      s_d.dq_oe     = 1'b0;
      s_d.wait_flag = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge REF_CLK) begin
    s_q <= s_d;
  end

  // outputs straight from the state register
  assign DQ_O       = s_q.dq;
  assign DQ_OE      = s_q.dq_oe;
  assign WAIT_O     = s_q.wait_flag;
  assign ARRAY_ADDR = s_q.waddr;

endmodule // flash_sync_read_mode_control

// [tb/flash_read_checker_assertions.sv]
`include "flash_read_cfg.svh"

// pin-level watcher of the read controller
module flash_read_checker (
  input wire logic               REF_CLK,
  input wire logic               RST,
  input wire logic               BUS_CLK,
  input wire logic               CE_N,
  input wire logic               OE_N,
  input wire logic               ADDRESS_LATCH_STROBE_N,
  input wire logic [`ADDR_W-1:0] ADDR,
  input wire logic [15:0]        DQ_O,
  input wire logic               DQ_OE,
  input wire logic               WAIT_O,
  input wire logic [`ADDR_W-1:0] ARRAY_ADDR
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);

  logic               strobe_q;  // strobe one cycle ago
  logic [`ADDR_W-1:0] cap_q;     // pin address at strobe release

  // keep the pin address seen at each strobe release
  always_ff @(posedge REF_CLK) begin
    strobe_q <= ADDRESS_LATCH_STROBE_N;
    if (ADDRESS_LATCH_STROBE_N && !strobe_q) begin
      cap_q <= ADDR;
    end
  end

  // driving, with clock, address, strobe and enables still
  sequence quiet_s;
    DQ_OE && $stable(BUS_CLK) && $stable(ADDR) && $stable(ADDRESS_LATCH_STROBE_N)
      && $stable(CE_N) && $stable(OE_N);
  endsequence

  // selected device sees the strobe go inactive
  sequence release_s;
    $rose(ADDRESS_LATCH_STROBE_N) && !CE_N && !OE_N;
  endsequence

  reset_values_a: assert property (disable iff (1'b0) RST |=> !DQ_OE && WAIT_O && DQ_O == 16'h0000 && ARRAY_ADDR == 20'h00000)
    else $error("outputs not at reset values");
  word_stands_a: assert property (quiet_s [*6] |=> $stable(DQ_O) && $stable(WAIT_O))
    else $error("data changed without a clock rise");
  // burst address taken only at strobe or clock
  addr_stands_a: assert property (quiet_s [*6] |=> $stable(ARRAY_ADDR))
    else $error("array address moved on a quiet bus");
  addr_capture_a: assert property (release_s |-> ##[1:8] (ARRAY_ADDR == cap_q))
    else $error("address not latched at strobe release");
  deselect_float_a: assert property ((CE_N || OE_N) [*5] |-> !DQ_OE)
    else $error("bus driven while deselected");
  deselect_wait_a: assert property (CE_N [*5] |-> WAIT_O)
    else $error("wait low while deselected");
  // driving starts only after both enables
  enable_drive_a: assert property ($rose(DQ_OE) |-> $past(CE_N, 2) == 1'b0 && $past(OE_N, 2) == 1'b0)
    else $error("bus driven without both enables");
  // valid word only on a driven bus
  wait_valid_a: assert property ($fell(WAIT_O) |-> DQ_OE && !CE_N)
    else $error("wait fell with bus not driven");
endmodule // flash_read_checker

bind flash_sync_read_mode_control flash_read_checker chk (.REF_CLK, .RST, .BUS_CLK, .CE_N, .OE_N,
  .ADDRESS_LATCH_STROBE_N, .ADDR, .DQ_O, .DQ_OE, .WAIT_O, .ARRAY_ADDR);

// [tb/flash_host_model.sv]
// host bus side; pins change only at falling reference edges
module flash_host_model (
  input  wire logic        ref_clk,
  output logic             bus_clk,
  output logic             ce_n,
  output logic             oe_n,
  output logic             we_n,
  output logic             als_n,
  output logic [19:0]      addr,
  output logic [15:0]      dq_i
);
  timeunit 1ns;
  timeprecision 1ns;

  // idle: deselected, strobe off, clock parked low
  initial begin
    bus_clk = 1'b0;
    ce_n    = 1'b1;
    oe_n    = 1'b1;
    we_n    = 1'b1;
    als_n   = 1'b1;
    addr    = 20'h00000;
    dq_i    = 16'h0000;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // command write, output enable kept off
  task automatic cmd(input logic [19:0] a, input logic [7:0] code);
    idle(1);
    addr = a;
    dq_i = {8'h00, code};
    ce_n = 1'b0;
    we_n = 1'b0;
    idle(4);
    we_n = 1'b1;
    idle(4);
    ce_n = 1'b1;
    // released lines show the inverse, never the stale word
    dq_i = ~dq_i;
    idle(4);
  endtask

  // select and pulse the strobe, or keep it low
  task automatic start(input logic [19:0] a, input logic hold);
    idle(1);
    addr = a;
    ce_n = 1'b0;
    oe_n = 1'b0;
    als_n = 1'b0;
    idle(4);
    als_n = ~hold;
    idle(8);
  endtask

  // address lines no longer held once latched
  task automatic flip();
    addr = ~addr;
  endtask

  // one 400 ns bus clock period; returns just before the next rise
  task automatic pulse();
    idle(1);
    bus_clk = 1'b1;
    idle(4);
    bus_clk = 0;
    idle(3);
  endtask

  task automatic stop();
    idle(1);
    ce_n = 1'b1;
    oe_n = 1'b1;
    als_n = 1'b1;
    addr = ~addr;
    idle(6);
  endtask
endmodule // flash_host_model

// [tb/flash_sync_read_mode_control_tb.sv]
module flash_sync_read_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [15:0] MAKER = 16'h00c3;  // arbitrary value
  localparam logic [15:0] PART  = 16'h3c5a;  // arbitrary value

  logic        ref_clk, rst;
  logic [3:0]  busy;                  // per-partition busy
  logic        prot_en;
  logic [3:0]  prot_idx;
  logic [15:0] prot_data;
  logic        bus_clk, ce_n, oe_n, we_n, als_n;
  logic [19:0] addr, arr_addr;
  logic [15:0] dq_i, dq_o;
  logic        dq_oe, wait_o;
  int          mismatches, tests_run;
  // array core: word tied to its address, answers same cycle
  wire  [15:0] arr_data = arr_addr[15:0] ^ 16'h3c00;

  flash_host_model host (.ref_clk(ref_clk), .bus_clk(bus_clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .als_n(als_n), .addr(addr), .dq_i(dq_i));

  flash_sync_read_mode_control #(.MAKER_CODE(MAKER), .PART_CODE(PART)) DUT (.REF_CLK(ref_clk), .RST(rst),
    .BUS_CLK(bus_clk), .CE_N(ce_n), .OE_N(oe_n), .WE_N(we_n), .ADDRESS_LATCH_STROBE_N(als_n), .ADDR(addr),
    .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE(dq_oe), .WAIT_O(wait_o), .ARRAY_ADDR(arr_addr), .ARRAY_DATA(arr_data),
    .QUERY_DATA({8'h51, arr_addr[7:0]}), .STATUS_DATA({6'h21, arr_addr[19:18]}), .BLOCK_LOCK(arr_addr[9:8]),
    .PART_BUSY(busy), .PROT_WR_EN(prot_en), .PROT_WR_IDX(prot_idx), .PROT_WR_DATA(prot_data));

  // 20 MHz reference clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [15:0] arr(input logic [19:0] a);
    return a[15:0] ^ 16'h3c00;
  endfunction

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  task automatic print_verdict();
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // configuration pair aimed at partition 3, which then reads array again
  task automatic set_cfg(input logic [15:0] c);
    host.cmd({4'hc, c}, 8'h60);
    host.cmd({4'hc, c}, 8'h03);
    host.cmd(20'hc0000, 8'hff);
  endtask

  // latency rises with wait high, n words, wait high after a bounded length
  task automatic burst(input logic [19:0] a, input int lat, input int n, input logic [15:0] first,
                       input logic step, input logic bounded);
    logic [15:0] w;
    w = first;
    host.start(a, 1'b0);
    host.flip();
    for (int i = 0; i < lat; i++) begin
      host.pulse();
      check("wait in latency", 16'h0001, {15'h0, wait_o});
    end
    for (int i = 0; i < n; i++) begin
      host.pulse();
      check("burst word", w, dq_o);
      check("wait in burst", 16'h0000, {15'h0, wait_o});
      w = w + {15'h0, step};
    end
    if (bounded) begin
      host.pulse();
      check("wait after length", 16'h0001, {15'h0, wait_o});
    end
    host.stop();
    check("bus released", 16'h0000, {15'h0, dq_oe});
  endtask

  // reset state and an asynchronous array read with no command
  task automatic t_async();
    check("bus after reset", 16'h0000, {15'h0, dq_oe});
    check("wait after reset", 16'h0001, {15'h0, wait_o});
    host.start(20'h80123, 1'b0);
    check("async word", arr(20'h80123), dq_o);
    check("async wait", 16'h0001, {15'h0, wait_o});
    host.stop();
  endtask

  // continuous at latency 0, then 16, 8, 4 words at latency 3, 2, 1
  task automatic t_lengths();
    set_cfg(16'h0007);
    burst(20'h00010, 0, 20, arr(20'h00010), 1'b1, 1'b0);
    for (int c = 3; c >= 1; c--) begin
      set_cfg({2'b00, 3'(c), 8'h00, 3'(c)});
      burst(20'h00010, c, 4 << (c - 1), arr(20'h00010), 1'b1, 1'b1);
    end
  endtask

  // identifier space of partition 1; partition 0 keeps array reads
  task automatic t_ident();
    @(negedge ref_clk);
    prot_en = 1'b1;
    prot_data = 16'hfffd;
    @(negedge ref_clk);
    prot_idx = 4'h1;
    prot_data = 16'h1234;
    @(negedge ref_clk);
    prot_en = 1'b0;
    host.cmd(20'h40000, 8'h90);
    burst(20'h40000, 1, 4, MAKER, 1'b0, 1'b1);
    burst(20'h40001, 1, 4, PART, 1'b0, 1'b1);
    burst(20'h40005, 1, 4, 16'h0801, 1'b0, 1'b1);
    burst(20'h40003, 1, 4, 16'h0000, 1'b0, 1'b1);
    burst(20'h40202, 1, 4, 16'h0002, 1'b0, 1'b1);
    burst(20'h40080, 1, 4, 16'hfffd, 1'b0, 1'b1);
    burst(20'h40081, 1, 4, 16'h1234, 1'b0, 1'b1);
    burst(20'h00020, 1, 4, arr(20'h00020), 1'b1, 1'b1);
  endtask

  // query, identifier and status on a busy partition
  task automatic t_modes();
    busy = 4'h2;
    host.cmd(20'h40000, 8'h98);
    burst(20'h40010, 1, 4, 16'h5110, 1'b0, 1'b1);
    host.cmd(20'h40000, 8'h90);
    burst(20'h40001, 1, 4, PART, 1'b0, 1'b1);
    host.cmd(20'h40000, 8'h20);
    burst(20'h40000, 1, 4, 16'h0085, 1'b0, 1'b1);
    host.cmd(20'h40000, 8'h98);
    host.cmd(20'h40000, 8'h70);
    burst(20'h40000, 1, 4, 16'h0085, 1'b0, 1'b1);
    busy = 4'h0;
  endtask

  // busy array partition gives invalid words; deselect in mid-burst
  task automatic t_busy();
    busy = 4'h4;
    host.cmd(20'h80000, 8'hff);
    host.start(20'h80040, 1'b0);
    host.pulse();
    host.pulse();
    check("busy word", 16'hffff, dq_o);
    check("busy wait", 16'h0001, {15'h0, wait_o});
    host.stop();
    check("bus released", 16'h0000, {15'h0, dq_oe});
    busy = 4'h0;
    burst(20'h80040, 1, 4, arr(20'h80040), 1'b1, 1'b1);
  endtask

  // strobe held low: address taken at the first clock rise
  task automatic t_hold();
    int k;
    k = 0;
    host.start(20'h00030, 1'b1);
    host.pulse();
    host.flip();
    while (wait_o !== 1'b0 && k < 6) begin
      host.pulse();
      k++;
    end
    check("held strobe word", arr(20'h00030), dq_o);
    host.pulse();
    check("held strobe next", arr(20'h00031), dq_o);
    host.stop();
  endtask

  // mid-run reset: synchronous config and partition 1 status are dropped
  task automatic t_reset();
    rst = 1'b1;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    check("bus after reset", 16'h0000, {15'h0, dq_oe});
    host.start(20'h40123, 1'b0);
    check("reset async word", arr(20'h40123), dq_o);
    check("reset async wait", 16'h0001, {15'h0, wait_o});
    host.stop();
  endtask

  // main sequence: 12-cycle reset, then the scenarios
  initial begin
    rst = 1'b1;
    busy = 4'h0;
    prot_en = 1'b0;
    prot_idx = 4'h0;
    prot_data = 16'h0000;
    mismatches = 0;
    tests_run = 0;
    repeat (12) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    t_async();
    t_lengths();
    t_ident();
    t_modes();
    t_busy();
    t_hold();
    t_reset();
    print_verdict();
  end

  // watchdog, well beyond the expected run
  initial begin
    #1000000;
    mismatches++;
    print_verdict();
  end
endmodule // flash_sync_read_mode_control_tb
